// *** src/swp_pkg.sv ***
package swp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices; the byte address is four times the index.
   localparam logic [11:0] IDX_GLOBAL = 12'h002;
   localparam logic [11:0] IDX_TAILTAG = 12'h003;
   localparam logic [11:0] IDX_PORT1 = 12'h012;
   localparam logic [11:0] IDX_PORT2 = 12'h022;
   localparam logic [11:0] IDX_STATUS = 12'h040;
   localparam logic [11:0] ADDR_GLOBAL = {IDX_GLOBAL[9:0], 2'b00};
   localparam logic [11:0] ADDR_TAILTAG = {IDX_TAILTAG[9:0], 2'b00};
   localparam logic [11:0] ADDR_PORT1 = {IDX_PORT1[9:0], 2'b00};
   localparam logic [11:0] ADDR_PORT2 = {IDX_PORT2[9:0], 2'b00};
   localparam logic [11:0] ADDR_STATUS = {IDX_STATUS[9:0], 2'b00};

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values.
   localparam int unsigned GLB_FLUSH_DYN = 5;
   localparam int unsigned GLB_FLUSH_STA = 4;
   localparam int unsigned TT_ENABLE = 6;
   localparam int unsigned PC_TX_EN = 2;
   localparam int unsigned PC_RX_EN = 1;
   localparam int unsigned PC_LRN_DIS = 0;
   localparam int unsigned ST_BUSY = 6;
   localparam logic [7:0] GLOBAL_RST = 8'h00;
   localparam logic [7:0] TAILTAG_RST = 8'h00;
   localparam logic [7:0] PORTCTRL_RST = 8'h06;
   localparam logic [7:0] GLB_FLUSH_MASK = 8'h30;
   localparam int unsigned FLUSH_CYCLES_DEF = 64;

   ////////////////////////////////////////////////////////////////////////////
   // Ports, masks and bus answers.
   localparam logic [1:0] PORT_NONE = 2'h0;
   localparam logic [1:0] PORT_CPU = 2'h3;
   localparam logic [1:0] TAG_LOOKUP = 2'h0;
   localparam logic [2:0] MASK_CPU = 3'h4;
   localparam logic [2:0] MASK_NONE = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SWP_DISCARD = 3'b001,
      SWP_LEARN = 3'b010,
      SWP_FORWARD = 3'b100
   } swp_stp_t;

   // One received frame after address lookup: source port 1..3, lookup
   // destination mask (bit 0 port 1, bit 1 port 2, bit 2 processor port).
   typedef struct packed {
      logic [1:0] src_port;
      logic [2:0] lookup_mask;
      logic override;
      logic [1:0] tail_tag;
   } swp_frame_t;

   typedef struct packed {
      logic [2:0] dest_mask;
      logic learn;
   } swp_dec_t;

endpackage : swp_pkg

// *** src/swp_fwd_filter.sv ***
`timescale 1ns/100ps
module swp_fwd_filter import swp_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic frm_valid,
   input wire swp_frame_t frm,
   input wire logic [1:0] tx_en,
   input wire logic [1:0] rx_en,
   input wire logic [1:0] lrn_dis,
   input wire logic [1:0] flushing,
   input wire logic tail_en,
   output logic dec_valid,
   output swp_dec_t dec
);

   logic dec_valid_reg;
   swp_dec_t dec_reg;
   swp_dec_t dec_next;
   wire logic p_idx = frm.src_port[1];

   always_comb begin
      dec_next = '{dest_mask: MASK_NONE, learn: 1'b0};
      if (frm.src_port == PORT_CPU) begin
         if (tail_en && frm.tail_tag != TAG_LOOKUP) begin
            dec_next.dest_mask = {1'b0, frm.tail_tag};
         end else begin
            dec_next.dest_mask = {1'b0, frm.lookup_mask[1:0] & tx_en};
         end
         dec_next.learn = 1'b1;
      end else if (frm.src_port != PORT_NONE) begin
         if (rx_en[p_idx]) begin
            dec_next.dest_mask = frm.lookup_mask & {1'b1, tx_en};
         end else if (frm.override && frm.lookup_mask[2]) begin
            dec_next.dest_mask = MASK_CPU;
         end
         dec_next.learn = !lrn_dis[p_idx] && !flushing[p_idx];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dec_valid_reg <= 1'b0;
         dec_reg <= '0;
      end else begin
         dec_valid_reg <= frm_valid;
         dec_reg <= dec_next;
      end
   end

   assign dec_valid = dec_valid_reg;
   assign dec = dec_reg;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   wire logic user_in = frm_valid && frm.src_port inside {2'h1, 2'h2};

   AST_NO_USER_RX: assert property (
      user_in && !rx_en[p_idx] |=> dec_valid && dec.dest_mask[1:0] == 2'b00)
      else $error("blocked port passed user traffic");
   AST_OVERRIDE_CPU: assert property (
      user_in && !rx_en[p_idx] && frm.override && frm.lookup_mask[2]
      |=> dec.dest_mask == MASK_CPU)
      else $error("override frame not delivered to processor");
   AST_FWD_NORMAL: assert property (
      user_in && rx_en[p_idx] && tx_en == 2'b11 |=> dec.dest_mask == $past(frm.lookup_mask))
      else $error("forwarding port altered the lookup result");
   AST_LEARN_GATE: assert property (
      user_in |=> dec.learn == !($past(lrn_dis[p_idx]) || $past(flushing[p_idx])))
      else $error("learning does not follow the learning disable bit");
   AST_TAIL_DEST: assert property (
      frm_valid && frm.src_port == PORT_CPU && tail_en && frm.tail_tag != TAG_LOOKUP
      |=> dec.dest_mask == {1'b0, $past(frm.tail_tag)})
      else $error("tail tag did not select the destination");

endmodule : swp_fwd_filter

// *** src/swp_stp_ctrl.sv ***
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
// How it works
// - Port 3 fixed processor port, no state.
// - Ports 1,2 own tx, rx, learn bits.
// - Tx/rx off, learn off: no traffic.
// - Override static hits still reach processor.
// - Blocking forwards only processor-bound frames.
// - Listening passes processor traffic both ways.
// - Learning state learns, passes processor traffic.
// - All enabled: forward normally and learn.
// - Global flush bits purge port table entries.
// - Discarding equals disabled, blocking, listening bits.
// - Processor attaches to port 3 by MII.
// - Tail tag bits 1:0 pick destination.
module swp_stp_ctrl import swp_pkg::*; #(
   parameter int unsigned FLUSH_CYCLES = FLUSH_CYCLES_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic frm_valid,
   input wire swp_frame_t frm,
   output logic dec_valid,
   output swp_dec_t dec,
   output logic [1:0] flush_dyn,
   output logic [1:0] flush_sta
);

   if (FLUSH_CYCLES < 1 || FLUSH_CYCLES > 256) begin : g_chk
      $error("FLUSH_CYCLES must lie in 1..256");
   end

   localparam logic [7:0] FLUSH_LOAD = 8'(FLUSH_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave state.
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic [11:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   // Configuration and flush state.
   logic [7:0] glb_reg;
   logic [7:0] tt_reg;
   logic [1:0][7:0] pc_reg;
   logic [1:0] flush_dyn_reg;
   logic [1:0] flush_sta_reg;
   logic [7:0] flush_cnt_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Write and read decode.
   wire logic aw_hs = s_axi_awvalid && awready_reg;
   wire logic w_hs = s_axi_wvalid && wready_reg;
   wire logic wr_go = !awready_reg && !wready_reg && !bvalid_reg;
   wire logic wr_lane = wstrb_reg[0];
   wire logic wr_glb = wr_go && wr_lane && awaddr_reg == ADDR_GLOBAL;
   wire logic wr_tt = wr_go && wr_lane && awaddr_reg == ADDR_TAILTAG;
   wire logic [1:0] wr_pc;
   wire logic wr_hit = awaddr_reg inside {ADDR_GLOBAL, ADDR_TAILTAG, ADDR_PORT1,
      ADDR_PORT2, ADDR_STATUS};
   wire logic ar_hs = s_axi_arvalid && arready_reg;
   wire logic rd_hit = s_axi_araddr inside {ADDR_GLOBAL, ADDR_TAILTAG, ADDR_PORT1,
      ADDR_PORT2, ADDR_STATUS};

   wire logic flush_busy = |{flush_dyn_reg, flush_sta_reg};
   wire logic flush_req = wr_glb && |(wdata_reg[7:0] & GLB_FLUSH_MASK);
   wire logic flush_start = flush_req && !flush_busy;

   ////////////////////////////////////////////////////////////////////////////
   // Per-port control fields and decoded spanning tree state.
   wire logic [1:0] tx_en;
   wire logic [1:0] rx_en;
   wire logic [1:0] lrn_dis;
   swp_stp_t port_state [2];

   for (genvar i = 0; i < 2; i++) begin : g_port
      localparam logic [11:0] PORT_ADDR = (i == 0) ? ADDR_PORT1 : ADDR_PORT2;
      assign wr_pc[i] = wr_go && wr_lane && awaddr_reg == PORT_ADDR;
      assign tx_en[i] = pc_reg[i][PC_TX_EN];
      assign rx_en[i] = pc_reg[i][PC_RX_EN];
      assign lrn_dis[i] = pc_reg[i][PC_LRN_DIS];
      assign port_state[i] = (tx_en[i] && rx_en[i]) ? SWP_FORWARD :
         (!lrn_dis[i] ? SWP_LEARN : SWP_DISCARD);

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            pc_reg[i] <= PORTCTRL_RST;
         end else if (wr_pc[i]) begin
            pc_reg[i] <= {5'h00, wdata_reg[2:0]};
         end
      end
   end

   // Read data multiplexer; reserved bits read as zero.
   wire logic [7:0] glb_view = {glb_reg[7:6], |flush_dyn_reg, |flush_sta_reg,
      glb_reg[3:0]};
   wire logic [7:0] status_view = {1'b0, flush_busy, port_state[1], port_state[0]};
   wire logic [7:0] rd_byte =
      (s_axi_araddr == ADDR_GLOBAL) ? glb_view :
      (s_axi_araddr == ADDR_TAILTAG) ? tt_reg :
      (s_axi_araddr == ADDR_PORT1) ? pc_reg[0] :
      (s_axi_araddr == ADDR_PORT2) ? pc_reg[1] :
      (s_axi_araddr == ADDR_STATUS) ? status_view : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken in either order, answer after both.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         awaddr_reg <= 12'h000;
      end else if (aw_hs) begin
         awready_reg <= 1'b0;
         awaddr_reg <= s_axi_awaddr;
      end else if (bvalid_reg && s_axi_bready) begin
         awready_reg <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_reg <= 1'b1;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else if (w_hs) begin
         wready_reg <= 1'b0;
         wdata_reg <= s_axi_wdata;
         wstrb_reg <= s_axi_wstrb;
      end else if (bvalid_reg && s_axi_bready) begin
         wready_reg <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel: data one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end else if (ar_hs) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= {24'h00_0000, rd_byte};
         rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Global and tail tag registers. Flush bits are not stored; they read back
   // as the running flush.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         glb_reg <= GLOBAL_RST;
         tt_reg <= TAILTAG_RST;
      end else begin
         if (wr_glb) begin
            glb_reg <= wdata_reg[7:0] & ~GLB_FLUSH_MASK;
         end
         if (wr_tt) begin
            tt_reg <= wdata_reg[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flush sequencer. The ports with learning disabled are purged from the
   // chosen tables for FLUSH_CYCLES cycles; a request while busy is ignored,
   // so a second flush cannot cut the first one short.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flush_dyn_reg <= 2'b00;
         flush_sta_reg <= 2'b00;
         flush_cnt_reg <= 8'h00;
      end else if (flush_start) begin
         flush_dyn_reg <= wdata_reg[GLB_FLUSH_DYN] ? lrn_dis : 2'b00;
         flush_sta_reg <= wdata_reg[GLB_FLUSH_STA] ? lrn_dis : 2'b00;
         flush_cnt_reg <= FLUSH_LOAD;
      end else if (flush_busy) begin
         if (flush_cnt_reg == 8'h00) begin
            flush_dyn_reg <= 2'b00;
            flush_sta_reg <= 2'b00;
         end else begin
            flush_cnt_reg <= flush_cnt_reg - 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Forwarding decision per frame; port 3 carries the processor over MII.
   // processor port fixed
   swp_fwd_filter u_filter (
      .aclk(aclk),
      .aresetn(aresetn),
      .frm_valid(frm_valid),
      .frm(frm),
      .tx_en(tx_en),
      .rx_en(rx_en),
      .lrn_dis(lrn_dis),
      .flushing(flush_dyn_reg | flush_sta_reg),
      .tail_en(tt_reg[TT_ENABLE]),
      .dec_valid(dec_valid),
      .dec(dec)
   );

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign flush_dyn = flush_dyn_reg;
   assign flush_sta = flush_sta_reg;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_flush_req;
      flush_start;
   endsequence

   sequence s_flush_run;
      flush_busy && flush_cnt_reg == FLUSH_LOAD;
   endsequence

   sequence s_b_done;
      s_axi_bvalid && s_axi_bready;
   endsequence

   // A write that must leave every register untouched.
   sequence s_wr_void;
      wr_go && (!wr_lane || !wr_hit || awaddr_reg == ADDR_STATUS);
   endsequence

   AST_WR_PORTCTRL: assert property (
      wr_pc[0] |=> pc_reg[0][2:0] == $past(wdata_reg[2:0]) && bvalid_reg)
      else $error("port 1 control write not applied");
   AST_FLUSH_SEL: assert property (
      s_flush_req |=> flush_dyn_reg == ($past(wdata_reg[GLB_FLUSH_DYN]) ?
         $past(lrn_dis) : 2'b00))
      else $error("flush did not target learning-disabled ports");
   AST_FLUSH_LEN: assert property (
      s_flush_req ##0 (lrn_dis != 2'b00) |=> s_flush_run)
      else $error("flush did not load its count");
   AST_FLUSH_STEP: assert property (
      flush_busy && flush_cnt_reg != 8'h00
      |=> flush_busy && flush_cnt_reg == $past(flush_cnt_reg) - 8'h01)
      else $error("flush counter did not step down");
   AST_FLUSH_END: assert property (
      flush_busy && flush_cnt_reg == 8'h00 |=> !flush_busy)
      else $error("flush did not end after its count");
   AST_FLUSH_IGNORE: assert property (
      flush_req && flush_busy |=> flush_dyn_reg == ($past(flush_cnt_reg) == 8'h00 ? 2'b00 :
         $past(flush_dyn_reg)))
      else $error("flush request while busy was not ignored");
   AST_WR_GLB: assert property (
      wr_glb |=> glb_reg == ($past(wdata_reg[7:0]) & ~GLB_FLUSH_MASK))
      else $error("global control write not applied");
   AST_RD_ANSWER: assert property (
      ar_hs |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered one cycle after address");
   AST_WR_ANSWER: assert property (
      wr_go |=> s_axi_bvalid && s_axi_bresp == ($past(wr_hit) ? RESP_OKAY : RESP_SLVERR))
      else $error("write response missing or wrong");

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer and status checks.
   AST_WR_VOID: assert property (
      s_wr_void |=> $stable(pc_reg) && $stable(glb_reg) && $stable(tt_reg))
      else $error("refused or masked write changed a register");
   AST_B_DONE: assert property (
      s_b_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write answer not released after its handshake");
   AST_B_PEND: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("new write accepted while an answer is pending");
   AST_RD_REFUSE: assert property (
      ar_hs && !rd_hit |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   AST_RD_DONE: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read answer not released after its handshake");
   AST_R_PEND: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("new read accepted while an answer is pending");
   AST_ST_DISCARD: assert property (
      ar_hs && s_axi_araddr == ADDR_STATUS && !tx_en[0] && !rx_en[0] && lrn_dis[0]
      |=> s_axi_rdata[2:0] == SWP_DISCARD)
      else $error("closed port not reported as discarding");
   AST_ST_LEARN: assert property (
      ar_hs && s_axi_araddr == ADDR_STATUS && !tx_en[1] && !rx_en[1] && !lrn_dis[1]
      |=> s_axi_rdata[5:3] == SWP_LEARN)
      else $error("learning port not reported as learning");

endmodule : swp_stp_ctrl

// *** verif/swp_host_model.sv ***
`timescale 1ns/100ps
module swp_host_model import swp_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic go,
   input wire logic [1:0] open_ports,
   output logic h_valid,
   output swp_frame_t h_frm
);

   int seed = 59232;
   logic [7:0] rnd;

   ////////////////////////////////////////////////////////////////////////////
   // The processor sends frames on its own port while asked to.
   // processor port source.
   always @(posedge aclk) begin
      rnd = 8'($random(seed));
      if (!aresetn) begin
         h_valid <= 1'b0;
         h_frm <= '0;
      end else begin
         h_valid <= go;
         h_frm.src_port <= PORT_CPU;
         h_frm.override <= 1'b0;
         h_frm.lookup_mask <= {rnd[2], rnd[1:0] & open_ports};
         h_frm.tail_tag <= rnd[4:3] & open_ports;
      end
   end

endmodule : swp_host_model

// *** verif/tb_switch_port_stp_state_control.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
   $display("[ERR] %0t value mismatch", $time); end end
module tb_switch_port_stp_state_control import swp_pkg::*; ;

   localparam int FL = 4;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, flush_dyn, flush_sta;
   logic b_valid, h_valid, h_go, dec_valid, frm_valid, tten;
   swp_frame_t b_frm, h_frm, frm;
   swp_dec_t dec;
   logic [2:0] c1, c2;
   logic [33:0] bq[$];
   swp_dec_t dq[$];
   int mismatches = 0, checks = 0, cnt_dyn = 0, cnt_sta = 0, seed = 59232, cpu_drop = 0;
   logic [2:0] tbl [3] = '{3'b001, 3'b000, 3'b110};
   logic [7:0] gl [3] = '{8'h31, 8'h20, 8'h10};

   assign frm_valid = b_valid | h_valid;
   assign frm = h_valid ? h_frm : b_frm;

   swp_stp_ctrl #(.FLUSH_CYCLES(FL)) uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .frm_valid(frm_valid), .frm(frm), .dec_valid(dec_valid),
      .dec(dec), .flush_dyn(flush_dyn), .flush_sta(flush_sta));

   swp_host_model host (.aclk(aclk), .aresetn(aresetn), .go(h_go),
      .open_ports({~c2[0], ~c1[0]}), .h_valid(h_valid), .h_frm(h_frm));

   always #4 aclk = ~aclk;

   ////////////////////////////////////////////////////////////////////////////
   // Expected decision from the port settings held by the bench.
   function automatic swp_dec_t exp_dec(swp_frame_t f);
      swp_dec_t e;
      logic [2:0] c;
      logic [1:0] tx;
      e = '0;
      tx = {c2[2], c1[2]};
      c = (f.src_port == 2'h2) ? c2 : c1;
      if (f.src_port == PORT_CPU) begin
         e.learn = 1'b1;
         if (tten && f.tail_tag != TAG_LOOKUP) e.dest_mask = {1'b0, f.tail_tag};
         else e.dest_mask = {1'b0, f.lookup_mask[1:0] & tx};
      end else if (f.src_port != PORT_NONE) begin
         e.learn = ~c[0];
         if (c[1]) e.dest_mask = f.lookup_mask & {1'b1, tx};
         else e.dest_mask = (f.override && f.lookup_mask[2]) ? MASK_CPU : MASK_NONE;
      end
      return e;
   endfunction : exp_dec

   function automatic logic [2:0] st(logic [2:0] c);
      return (c == 3'b001) ? 3'b001 : (c == 3'b000) ? 3'b010 : 3'b100;
   endfunction : st

   task automatic final_report();
      if (mismatches == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] r);
      int n;
      @(posedge aclk);
      bq.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      s_axi_wdata <= ~d;
      if (n == 50) begin mismatches++; final_report(); end
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge aclk);
      bq.push_back({r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 50) begin mismatches++; final_report(); end
   endtask : rd

   task automatic send_frm(input int n);
      swp_frame_t f;
      f = '0;
      for (int i = 0; i < n; i++) begin
         // Override static entries are hit at random.
         f = swp_frame_t'(8'($random(seed)));
         if (f.src_port == PORT_CPU) f.src_port = PORT_NONE;
         b_valid <= 1'b1;
         b_frm <= f;
         @(posedge aclk);
      end
      b_valid <= 1'b0;
      b_frm <= ~f;
   endtask : send_frm

   ////////////////////////////////////////////////////////////////////////////
   // Monitor: each answer is compared with the oldest note.
   always @(posedge aclk) begin
      if (dec_valid === 1'b1) begin
         if (dq.size() > 0) `CHK(dec, dq.pop_front())
         else `CHK(dec_valid, 1'b0)
      end
      if (frm_valid === 1'b1) dq.push_back(exp_dec(frm));
      // Count override frames from ports with receive off; these still reach the processor.
      if (frm_valid === 1'b1 && frm.src_port inside {2'h1, 2'h2} && frm.override &&
         frm.lookup_mask[2] && !(frm.src_port[1] ? c2[1] : c1[1])) cpu_drop++;
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
         `CHK({s_axi_bresp, 32'h0}, bq.pop_front())
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
         `CHK({s_axi_rresp, s_axi_rdata}, bq.pop_front())
      if (flush_dyn === 2'b01) cnt_dyn++;
      if (flush_sta === 2'b01) cnt_sta++;
   end

   initial begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, b_valid, h_go} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_wstrb, b_frm} = '0;
      c1 = PORTCTRL_RST[2:0];
      c2 = PORTCTRL_RST[2:0];
      tten = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ADDR_PORT1, {24'h0, PORTCTRL_RST}, RESP_OKAY);
      rd(ADDR_PORT2, {24'h0, PORTCTRL_RST}, RESP_OKAY);
      rd(ADDR_GLOBAL, {24'h0, GLOBAL_RST}, RESP_OKAY);
      rd(ADDR_TAILTAG, {24'h0, TAILTAG_RST}, RESP_OKAY);
      rd(ADDR_STATUS, 32'h24, RESP_OKAY);
      wr(12'h004, 32'hFF, 4'hF, RESP_SLVERR);
      rd(12'h004, 32'h0, RESP_SLVERR);
      wr(ADDR_PORT1, 32'h0, 4'h0, RESP_OKAY);
      wr(ADDR_STATUS, 32'h0, 4'hF, RESP_OKAY);
      rd(ADDR_PORT1, {24'h0, PORTCTRL_RST}, RESP_OKAY);
      for (int k = 0; k < 15; k++) begin
         if (k < 9) {c1, c2} = {tbl[k % 3], tbl[k / 3]};
         else {c1, c2} = 6'($random(seed));
         tten = k[0];
         wr(ADDR_PORT1, {29'h0, c1}, 4'hF, RESP_OKAY);
         wr(ADDR_PORT2, {29'h0, c2}, 4'hF, RESP_OKAY);
         wr(ADDR_TAILTAG, {25'h0, tten, 6'h0}, 4'hF, RESP_OKAY);
         rd(ADDR_PORT1, {29'h0, c1}, RESP_OKAY);
         rd(ADDR_PORT2, {29'h0, c2}, RESP_OKAY);
         if (k < 9) rd(ADDR_STATUS, {26'h0, st(c2), st(c1)}, RESP_OKAY);
         send_frm(20);
         h_go <= 1'b1;
         repeat (10) @(posedge aclk);
         h_go <= 1'b0;
         repeat (3) @(posedge aclk);
      end
      // flush of the port with learning off.
      c1 = 3'b001;
      c2 = 3'b110;
      wr(ADDR_PORT1, {29'h0, c1}, 4'hF, RESP_OKAY);
      wr(ADDR_PORT2, {29'h0, c2}, 4'hF, RESP_OKAY);
      for (int k = 0; k < 3; k++) begin
         cnt_dyn = 0;
         cnt_sta = 0;
         wr(ADDR_GLOBAL, {24'h0, gl[k]}, 4'hF, RESP_OKAY);
         if (k == 0) wr(ADDR_GLOBAL, {24'h0, gl[k]}, 4'hF, RESP_OKAY);
         repeat (FL + 6) @(posedge aclk);
         `CHK(cnt_dyn, (gl[k][5] ? FL : 0))
         `CHK(cnt_sta, (gl[k][4] ? FL : 0))
         rd(ADDR_GLOBAL, {24'h0, gl[k] & ~GLB_FLUSH_MASK}, RESP_OKAY);
      end
      repeat (3) @(posedge aclk);
      `CHK(cpu_drop > 0, 1'b1)
      `CHK(dq.size(), 0)
      final_report();
   end

endmodule : tb_switch_port_stp_state_control
